// file: src/brws_consts.svh
`ifndef BRWS_CONSTS_SVH
`define BRWS_CONSTS_SVH
`define BRWS_AW 16
`define BRWS_OFF_RCR 12'h000
`define BRWS_OFF_CTRL 12'h004
`define BRWS_OFF_STAT 12'h008
`define BRWS_RCR_RST 16'h9fcf
`define BRWS_RCR_MASK 16'hbfcf
`define BRWS_CTRL_RST 1'h1
`define BRWS_B_MODE 15
`define BRWS_LAT_HI 13
`define BRWS_LAT_LO 11
`define BRWS_B_POL 10
`define BRWS_B_HOLD 9
`define BRWS_B_WTIM 8
`define BRWS_B_WRAPD 3
`define BRWS_BL_HI 2
`define BRWS_BL_LO 0
`define BRWS_BL_4 3'h1
`define BRWS_BL_8 3'h2
`define BRWS_BL_16 3'h3
`define BRWS_BL_CONT 3'h7
`define BRWS_LEN_4 5'h04
`define BRWS_LEN_8 5'h08
`define BRWS_LEN_16 5'h10
`define BRWS_GRP 4
`define BRWS_ROW_LO 4'h0
`endif

// file: src/brws_pkg.sv
package brws_pkg;
`include "brws_consts.svh"
  typedef enum logic [1:0] {BRWS_IDLE, BRWS_LAT, BRWS_DATA, BRWS_ROWDLY} brws_state_t;
  typedef struct packed {
    logic [2:0] clk_sync;
    logic [2:0] adv_sync;
    logic [2:0] ce_sync;
    logic [2:0] wr_sync;
    logic [2:0][`BRWS_AW-1:0] addr_sync;
    logic lclk_level;
    logic [15:0] read_config_reg;
    logic array_mode;
    brws_state_t state;
    logic [2:0] cnt;
    logic hold_cnt;
    logic [`BRWS_AW-1:0] addr;
    logic [4:0] left;
    logic row_done;
    logic [1:0] st_lo;
    logic wait_q;
    logic wait_oe_n;
    logic dvalid;
    logic [`BRWS_AW-1:0] addr_q;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } brws_regs_t;
endpackage

// file: src/brws_read_ctrl.sv
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
// What this block does
// - sync array read: wait off only with valid data
// - sync non-array read: wait held asserted
// - async reads: wait driven asserted
// - writes and async reads assert wait
// - each burst word held one or two clocks
// - wait asserted during delay or cycle earlier
// - linear bursts may delay at row crossing
// - 4-word aligned start: no row delay
// - misaligned start: row delay at most once
// - row delay only if 16-word boundary crossed
// - last word of group: delay latency minus one
// - wait held asserted through row delay
// - wrap mode wraps within aligned group
// - no-wrap and continuous increment linearly
// - polarity bit: clear low, set high, default high
// - hold bit: clear one, set two, default two
// - timing bit: clear during, set early, default early
`include "brws_consts.svh"
module brws_read_ctrl
  import brws_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  input wire logic link_clk_in,
  input wire logic address_valid_n_in,
  input wire logic chip_en_n_in,
  input wire logic write_cycle_in,
  input wire logic [`BRWS_AW-1:0] start_addr_in,
  output logic wait_out,
  output logic wait_oe_n_out,
  output logic data_valid_out,
  output logic [`BRWS_AW-1:0] burst_addr_out
);
  brws_regs_t r_reg;
  brws_regs_t r_next;

  function automatic logic [4:0] burst_len(input logic [2:0] bl);
    unique case (bl)
      `BRWS_BL_4: burst_len = `BRWS_LEN_4;
      `BRWS_BL_8: burst_len = `BRWS_LEN_8;
      default: burst_len = `BRWS_LEN_16;
    endcase
  endfunction

  function automatic logic linear(input logic [15:0] read_config_reg);
    linear = read_config_reg[`BRWS_B_WRAPD] || (read_config_reg[`BRWS_BL_HI:`BRWS_BL_LO] == `BRWS_BL_CONT);
  endfunction

  // next word address, wrapping inside the aligned group when wrap is on
  function automatic logic [`BRWS_AW-1:0] next_addr(input brws_regs_t s);
    logic [`BRWS_AW-1:0] inc;
    logic [`BRWS_AW-1:0] m;
    inc = s.addr + `BRWS_AW'(1);
    m = `BRWS_AW'(burst_len(s.read_config_reg[`BRWS_BL_HI:`BRWS_BL_LO]) - 5'h01);
    if (linear(s.read_config_reg))
    begin
      next_addr = inc;
    end
    else
    begin
      next_addr = (s.addr & ~m) | (inc & m);
    end
  endfunction

  // row delay grows with the start offset in its 4-word group
  function automatic logic [2:0] row_delay(input brws_regs_t s);
    logic [3:0] sum;
    sum = {1'b0, s.read_config_reg[`BRWS_LAT_HI:`BRWS_LAT_LO]} + {2'b00, s.st_lo};
    if (sum > 4'(`BRWS_GRP))
    begin
      row_delay = 3'(sum - 4'(`BRWS_GRP));
    end
    else
    begin
      // short latency or low offset: no extra cycles
      row_delay = 3'h0;
    end
  endfunction

  // true while the word now out is the last before a row delay
  function automatic logic cross_due(input brws_regs_t s);
    logic [`BRWS_AW-1:0] nx;
    logic more;
    nx = next_addr(s);
    more = (s.read_config_reg[`BRWS_BL_HI:`BRWS_BL_LO] == `BRWS_BL_CONT) || (s.left > 5'h01);
    cross_due = linear(s.read_config_reg) && more
      && (nx[3:0] == `BRWS_ROW_LO)
      && !s.row_done
      && (s.st_lo != 2'h0)
      && (row_delay(s) != 3'h0);
  endfunction

  // a synchronised pin counts once its last two stages agree
  function automatic logic agreed_low(input logic [2:0] s);
    agreed_low = !s[1] && !s[2];
  endfunction

  function automatic logic agreed_high(input logic [2:0] s);
    agreed_high = s[1] && s[2];
  endfunction

  logic lrise;
  logic ce_on;
  logic adv_on;
  logic wr_on;
  logic sync_ok;
  logic apb_acc;
  logic not_ready;

  always_comb
  begin
    r_next = r_reg;
    r_next.clk_sync = {r_reg.clk_sync[1:0], link_clk_in};
    r_next.adv_sync = {r_reg.adv_sync[1:0], address_valid_n_in};
    r_next.ce_sync = {r_reg.ce_sync[1:0], chip_en_n_in};
    r_next.wr_sync = {r_reg.wr_sync[1:0], write_cycle_in};
    r_next.addr_sync = {r_reg.addr_sync[1:0], start_addr_in};
    // link rise once the two last stages agree high
    lrise = (r_reg.clk_sync[1] == r_reg.clk_sync[2]) && r_reg.clk_sync[2] && !r_reg.lclk_level;
    if (r_reg.clk_sync[1] == r_reg.clk_sync[2])
    begin
      r_next.lclk_level = r_reg.clk_sync[2];
    end
    ce_on = agreed_low(r_reg.ce_sync);
    adv_on = agreed_low(r_reg.adv_sync);
    wr_on = agreed_high(r_reg.wr_sync);
    // burst only in sync mode, array partition, no write
    sync_ok = !r_reg.read_config_reg[`BRWS_B_MODE] && r_reg.array_mode && !wr_on;

    if (!ce_on || !sync_ok)
    begin
      // refused: no data, wait stays asserted
      r_next.state = BRWS_IDLE;
    end
    else if (lrise)
    begin
      if (adv_on)
      begin
        // address strobe: load start, restart counters
        r_next.state = BRWS_LAT;
        r_next.addr = r_reg.addr_sync[2];
        r_next.st_lo = r_reg.addr_sync[2][1:0];
        r_next.cnt = r_reg.read_config_reg[`BRWS_LAT_HI:`BRWS_LAT_LO];
        r_next.left = burst_len(r_reg.read_config_reg[`BRWS_BL_HI:`BRWS_BL_LO]);
        r_next.hold_cnt = 1'b0;
        r_next.row_done = 1'b0;
      end
      else
      begin
        unique case (r_reg.state)
          BRWS_IDLE:
          begin
            // no burst open; only an address strobe starts one
            r_next.state = BRWS_IDLE;
          end
          BRWS_LAT, BRWS_ROWDLY:
          begin
            if (r_reg.cnt <= 3'h1)
            begin
              r_next.state = BRWS_DATA;
            end
            else
            begin
              r_next.cnt = r_reg.cnt - 3'h1;
            end
          end
          BRWS_DATA:
          begin
            if (r_reg.read_config_reg[`BRWS_B_HOLD] && !r_reg.hold_cnt)
            begin
              // first of two clocks of this word
              r_next.hold_cnt = 1'b1;
            end
            else
            begin
              r_next.hold_cnt = 1'b0;
              r_next.addr = next_addr(r_reg);
              r_next.left = r_reg.left - 5'h01;
              if (r_reg.read_config_reg[`BRWS_BL_HI:`BRWS_BL_LO] != `BRWS_BL_CONT && r_reg.left <= 5'h01)
              begin
                // last word of a fixed-length burst
                r_next.state = BRWS_IDLE;
              end
              else if (cross_due(r_reg))
              begin
                r_next.state = BRWS_ROWDLY;
                r_next.cnt = row_delay(r_reg);
                r_next.row_done = 1'b1;
              end
            end
          end
        endcase
      end
    end

    // wait asserted everywhere but valid sync array data, and in early timing also on the word before a row delay
    not_ready = !sync_ok
      || (r_next.state != BRWS_DATA)
      || (r_reg.read_config_reg[`BRWS_B_WTIM] && cross_due(r_next));
    if (not_ready)
    begin
      r_next.wait_q = r_reg.read_config_reg[`BRWS_B_POL];
    end
    else
    begin
      r_next.wait_q = !r_reg.read_config_reg[`BRWS_B_POL];
    end

    // pin driven only while the chip is enabled
    r_next.wait_oe_n = !ce_on;
    r_next.dvalid = ce_on && sync_ok && (r_next.state == BRWS_DATA);
    r_next.addr_q = r_next.addr;

    // first access cycle only; a standing pready blocks a repeat
    apb_acc = psel_in && penable_in && !r_reg.pready;
    r_next.pready = apb_acc;
    r_next.pslverr = 1'b0;
    if (apb_acc)
    begin
      r_next.prdata = 32'h0000_0000;
      unique case (paddr_in[11:0])
        `BRWS_OFF_RCR:
        begin
          if (pwrite_in)
          begin
            // reserved bits are kept at zero
            r_next.read_config_reg = pwdata_in[15:0] & `BRWS_RCR_MASK;
          end
          else
          begin
            r_next.prdata = {16'h0000, r_reg.read_config_reg};
          end
        end
        `BRWS_OFF_CTRL:
        begin
          if (pwrite_in)
          begin
            r_next.array_mode = pwdata_in[0];
          end
          else
          begin
            r_next.prdata = {31'h0000_0000, r_reg.array_mode};
          end
        end
        `BRWS_OFF_STAT:
        begin
          // read only; writes here are ignored
          if (!pwrite_in)
          begin
            r_next.prdata = {r_reg.addr_q, 12'h000, r_reg.state, r_reg.dvalid, r_reg.wait_q};
          end
        end
        default:
        begin
          // unmapped offset: error, no effect
          r_next.pslverr = 1'b1;
        end
      endcase
    end
  end

  // reset: idle, async mode, wait pin released
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      r_reg <= '0;
      r_reg.clk_sync <= 3'h0;
      r_reg.adv_sync <= 3'h7;
      r_reg.ce_sync <= 3'h7;
      r_reg.read_config_reg <= `BRWS_RCR_RST;
      r_reg.array_mode <= `BRWS_CTRL_RST;
      r_reg.state <= BRWS_IDLE;
      r_reg.wait_q <= 1'b1;
      r_reg.wait_oe_n <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // every output straight from a flop
  assign pready_out = r_reg.pready;
  assign prdata_out = r_reg.prdata;
  assign pslverr_out = r_reg.pslverr;
  assign wait_out = r_reg.wait_q;
  assign wait_oe_n_out = r_reg.wait_oe_n;
  assign data_valid_out = r_reg.dvalid;
  assign burst_addr_out = r_reg.addr_q;
endmodule // brws_read_ctrl

// file: sim/brws_read_ctrl_checker.sv
`timescale 1ns/1ns
module brws_chk (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic chip_en_n_in,
  input wire logic write_cycle_in,
  input wire logic wait_out,
  input wire logic wait_oe_n_out,
  input wire logic data_valid_out,
  input wire logic [15:0] burst_addr_out
);
  logic pol_reg;
  // asserted wait level as last written
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
    if (!arst_n_in)
      pol_reg <= 1'h1;
    else if (psel_in && penable_in && pwrite_in && pready_out && paddr_in[11:0] == 12'h0)
      pol_reg <= pwdata_in[10];
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  property p_wait_on; !data_valid_out && !wait_oe_n_out |-> wait_out == pol_reg; endproperty
  a_wait_on: assert property (p_wait_on) else $error("wait off, no data");
  property p_hold; $changed(burst_addr_out) |=> $stable(burst_addr_out) [*7]; endproperty
  a_hold: assert property (p_hold) else $error("word too short");
  property p_wr; write_cycle_in [*5] |-> !data_valid_out; endproperty
  a_wr: assert property (p_wr) else $error("data in write");
  property p_ce; chip_en_n_in [*5] |-> wait_oe_n_out && !data_valid_out; endproperty
  a_ce: assert property (p_ce) else $error("wait driven when deselected");
  property p_step;
    data_valid_out && $past(data_valid_out) && $changed(burst_addr_out)
      |-> $past(wait_out) != pol_reg;
  endproperty
  a_step: assert property (p_step) else $error("step in wait");
  property p_rdy; psel_in && penable_in && !pready_out |=> pready_out; endproperty
  a_rdy: assert property (p_rdy) else $error("late ready");
  property p_pulse; pready_out |=> !pready_out; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_err; pslverr_out |-> pready_out; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  c_burst: cover property ($rose(data_valid_out));
  c_early: cover property (data_valid_out && wait_out == pol_reg);
  c_err: cover property (pslverr_out);
endmodule // brws_chk
bind brws_read_ctrl brws_chk u_chk (.*);

// file: sim/brws_host_model.sv
`timescale 1ns/1ns
module brws_host_model (
  output logic link_clk_out,
  output logic adv_n_out,
  output logic ce_n_out,
  output logic wr_out,
  output logic [15:0] addr_out
);
  initial
  begin
    link_clk_out = 1'h0;
    adv_n_out = 1'h1;
    ce_n_out = 1'h1;
    wr_out = 1'h0;
    addr_out = 16'h0;
  end
  // fixed clock count, wait ignored; clock still between frames
  task automatic burst(input logic [15:0] a, input int n, input logic w);
    #7;
    ce_n_out = 1'h0;
    wr_out = w;
    adv_n_out = 1'h0;
    addr_out = a;
    repeat (n + 1)
    begin
      #80 link_clk_out = 1'h1;
      #80 link_clk_out = 1'h0;
      adv_n_out = 1'h1;
      addr_out = ~a;
    end
    ce_n_out = 1'h1;
    wr_out = 1'h0;
  endtask
endmodule // brws_host_model

// file: sim/brws_read_ctrl_tb.sv
`timescale 1ns/1ns
module brws_read_ctrl_tb;
  logic ref_clk_in, arst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, pslv;
  logic [31:0] paddr_in, pwdata_in, prdata_out, rd;
  logic lclk, adv_n, ce_n, wr, wait_out, oe_n, dv, pol;
  logic [15:0] sa, ba;
  logic [15:0] q[$];
  int err_total, checks, s0, s1, dv_n, woff, early, cyc;
  brws_read_ctrl uut (.ref_clk_in, .arst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .pready_out, .prdata_out, .pslverr_out, .link_clk_in(lclk),
    .address_valid_n_in(adv_n), .chip_en_n_in(ce_n), .write_cycle_in(wr), .start_addr_in(sa),
    .wait_out, .wait_oe_n_out(oe_n), .data_valid_out(dv), .burst_addr_out(ba));
  brws_host_model host (.link_clk_out(lclk), .adv_n_out(adv_n), .ce_n_out(ce_n),
    .wr_out(wr), .addr_out(sa));
  initial
  begin
    ref_clk_in = 1'h0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (dv === 1'h1 && (q.size() == 0 || ba !== q[$])) q.push_back(ba);
    if (dv === 1'h1) begin if (s0 < 0) s0 = cyc; s1 = cyc; dv_n++; end
    if (oe_n === 1'h0 && wait_out !== pol) woff++;
    if (dv === 1'h1 && wait_out === pol) early++;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel_in <= 1'h1; pwrite_in <= w; paddr_in <= {20'h0, a}; pwdata_in <= d;
    @(posedge ref_clk_in) penable_in <= 1'h1;
    n = 0;
    do begin @(posedge ref_clk_in); n++; end while (pready_out !== 1'h1 && n < 50);
    if (n == 50) begin err_total++; stop_test; end
    rd = prdata_out; pslv = pslverr_out;
    psel_in <= 1'h0; penable_in <= 1'h0;
    @(posedge ref_clk_in);
  endtask
  task automatic run(input logic [15:0] r, st, input int nw, gap, ew, input logic w);
    int lat, h, len;
    logic c;
    logic [15:0] e;
    lat = r[13:11] < 2 ? 1 : r[13:11];
    h = r[9] + 1;
    len = 4 << (r[2:0] - 1);
    c = r[2:0] == 3'h7;
    pol = r[10];
    apb(1'h1, 12'h0, {16'h0, r});
    q = {}; dv_n = 0; woff = 0; early = 0; s0 = -1;
    host.burst(st, lat + nw * h + gap + 3, w);
    repeat (10) @(posedge ref_clk_in);
    chk("n", (c && q.size() > nw) ? nw : q.size(), nw);
    for (int i = 0; i < nw; i++)
    begin
      e = (r[3] || c) ? 16'(st + i) : 16'((st & ~(len - 1)) | ((st + i) & (len - 1)));
      chk("a", q[i], e);
    end
    if (!c && nw > 0) chk("dv", dv_n, nw * h * 8);
    if (!c && nw > 0) chk("gap", s1 - s0 + 1 - dv_n, gap * 8);
    chk("ew", early, ew * 8);
    if (!c) chk("wo", woff, (nw * h - ew) * 8);
    $display("burst %h done", st);
  endtask
  initial
  begin
    arst_n_in = 1'h0; psel_in = 1'h0; penable_in = 1'h0; pwrite_in = 1'h0;
    paddr_in = 32'h0; pwdata_in = 32'h0; pol = 1'h1; s0 = -1;
    repeat (6) @(posedge ref_clk_in);
    arst_n_in <= 1'h1;
    @(posedge ref_clk_in);
    apb(1'h0, 12'h0, 32'h0);
    chk("rcr", rd, 32'h9fcf);
    chk("ok", pslv, 1'h0);
    apb(1'h0, 12'h4, 32'h0);
    chk("ctl", rd, 32'h1);
    apb(1'h0, 12'hc, 32'h0);
    chk("err", pslv, 1'h1);
    run(16'h9fcf, 16'h2, 0, 0, 0, 1'h0);
    apb(1'h0, 12'h8, 32'h0);
    chk("stat", rd, 32'h1);
    run(16'h1c01, 16'h2, 4, 0, 0, 1'h0);
    run(16'h1c0a, 16'h5, 8, 0, 0, 1'h0);
    run(16'h1c09, 16'hf, 4, 2, 0, 1'h0);
    run(16'h1d09, 16'hf, 4, 2, 1, 1'h0);
    run(16'h1a09, 16'h0, 4, 0, 0, 1'h0);
    run(16'h1c0f, 16'hc, 8, 0, 0, 1'h0);
    run(16'h1c0a, 16'h5, 0, 0, 0, 1'h1);
    apb(1'h1, 12'h4, 32'h0);
    run(16'h1c0a, 16'h5, 0, 0, 0, 1'h0);
    stop_test;
  end
endmodule // brws_read_ctrl_tb
